// [sim/mata_micro_rom.sv]
// Microcode store stand-in driving the microword bus from the counter.
// Assumes the mapper latches the word itself at the machine-cycle edge.
`timescale 1ns/1ps
module mata_micro_rom (
    input wire logic [mata_pkg::LC_W-1:0] counterBusLines,
    output mata_pkg::mata_microword_t microwordBus
);
    import mata_pkg::*;
    // ==========================================================
    // Lookup
    // Force line raised at 055, return flag at 200
    assign microwordBus = '{4'h0, counterBusLines == 11'h055, counterBusLines == 11'h200, {5'h00, counterBusLines}};
endmodule // mata_micro_rom

// [sim/test_microaddress_translation_array.sv]
// Bench for the next-address mapper: register rows, then a mapping run.
// Assumes the AXI4-Lite slave and a four-clock machine cycle.
`timescale 1ns/1ps
module test_microaddress_translation_array;
    import mata_pkg::*;
    typedef struct packed {
        logic [AXI_ADDR_W-1:0] a;
        logic [3:0] s;
        logic [31:0] d;
        logic [1:0] b;
        logic [31:0] q;
        logic [1:0] r;
    } mata_row_t;
    logic clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, inputWordOp = 0, jumpRequest = 0;
    logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, got;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] bField = 8'h00;
    logic [HOLD_W-1:0] dataAccessLines = 16'hA500;
    logic [LC_W-1:0] jumpAddress = 11'h055, counterBusLines, c;
    mata_microword_t microwordBus;
    mata_phase_t machinePhase;
    int n_errors = 0, checked = 0;
    // Partial strobe, read-only, unmapped and array reads
    mata_row_t rows [5] = '{
        '{ADDR_CTRL, 4'h3, 32'h1, RESP_SLVERR, 32'h0, RESP_OKAY},
        '{ADDR_STATUS, STRB_FULL, 32'hFFFFFFFF, RESP_OKAY, 32'h0, RESP_OKAY},
        '{ADDR_HOLDER, STRB_FULL, 32'hFFFFFFFF, RESP_OKAY, 32'h0, RESP_OKAY},
        '{13'h1C00, STRB_FULL, 32'h1, RESP_SLVERR, 32'h0, RESP_SLVERR},
        '{13'h0400, STRB_FULL, 32'h0, RESP_OKAY, 32'h0, RESP_OKAY}};

    microaddress_translation_array dut_u (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .microwordBus(microwordBus),
        .dataAccessLines(dataAccessLines), .interruptLatches(7'h00), .qSignal(1'b0),
        .jumpRequest(jumpRequest), .jumpAddress(jumpAddress), .returnAddress(11'h3A0),
        .inputWordOp(inputWordOp), .loadHolderOp(1'b0), .bField(bField),
        .counterBusLines(counterBusLines), .machinePhase(machinePhase));
    mata_micro_rom rom_u (.counterBusLines(counterBusLines), .microwordBus(microwordBus));

    // ==========================================================
    // Clock and watchdog
    initial forever #10 clk = ~clk;
    // Run needs some 120 cycles; cut off far beyond
    initial begin
        #100000;
        n_errors++;
        give_verdict();
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        chk({30'h0, g}, {30'h0, e});
    endtask
    task automatic give_verdict();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Each wait ends on the answer; a hang ends at the watchdog
    task automatic wr(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                rsp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [AXI_ADDR_W-1:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rsp = rresp;
                got = rdata;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    // Ops held for the resolve clock only, then counter sampled
    task automatic mcycle(input logic iw, input logic [7:0] bf, input logic jr);
        int t;
        t = 0;
        do begin
            @(posedge clk);
            #1;
            t++;
        end while (machinePhase !== PH_CODE && t < 8);
        @(posedge clk);
        inputWordOp <= iw;
        bField <= bf;
        jumpRequest <= jr;
        @(posedge clk);
        inputWordOp <= 1'b0;
        jumpRequest <= 1'b0;
        #1;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(32'(counterBusLines), 32'(LC_RESET));
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rows[i].s);
            chk_resp(rsp, rows[i].b);
            rd(rows[i].a);
            chk(got, rows[i].q);
            chk_resp(rsp, rows[i].r);
        end
        // Third word 16 wants upper byte A5; fourth loads 123 and phase 4
        wr(13'h0C40, 32'h0000A55A, STRB_FULL);
        wr(13'h1040, 32'h00016123, STRB_FULL);
        // Plain code 3E, force code 4F; third word 17 wants code bit 6, fourth loads 200
        wr(13'h0800, 32'h0000003E, STRB_FULL);
        wr(13'h0960, 32'h0000004F, STRB_FULL);
        wr(13'h0C44, 32'h00400000, STRB_FULL);
        wr(13'h1044, 32'h00010200, STRB_FULL);
        wr(ADDR_CTRL, 32'h1, STRB_FULL);
        mcycle(1'b0, 8'h00, 1'b0);
        c = counterBusLines;
        mcycle(1'b1, 8'h01, 1'b0);
        chk(32'(counterBusLines), 32'(c + LC_STEP));
        mcycle(1'b1, 8'h20, 1'b0);
        chk(32'(counterBusLines), 32'(c + 11'h002));
        mcycle(1'b0, 8'h00, 1'b0);
        chk(32'(counterBusLines), 32'h123);
        mcycle(1'b0, 8'h00, 1'b0);
        chk(32'(counterBusLines), 32'h124);
        rd(ADDR_HOLDER);
        chk(got, 32'h0000A500);
        rd(ADDR_STATUS);
        chk(32'(got[14:12]), 32'h4);
        mcycle(1'b0, 8'h00, 1'b1);
        chk(32'(counterBusLines), 32'h055);
        repeat (2) mcycle(1'b0, 8'h00, 1'b0);
        chk(32'(counterBusLines), 32'h200);
        repeat (2) mcycle(1'b0, 8'h00, 1'b0);
        chk(32'(counterBusLines), 32'h3A0);
        give_verdict();
    end
endmodule // test_microaddress_translation_array

// [src/mata_match_plane.sv]
// Programmable match plane: each word holds a pattern, a 1 places an element.
// Assumes patterns are written one word at a time by the bus slave.
`timescale 1ns/1ps
module mata_match_plane #(
    parameter int WORDS = 88,
    parameter int WIDTH = 24,
    parameter int SPLIT = 0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wrEn,
    input wire logic [mata_pkg::IDX_W-1:0] wrIdx,
    input wire logic [mata_pkg::AXI_DATA_W-1:0] wrData,
    input wire logic [WIDTH-1:0] inLow,
    input wire logic [WIDTH-1:0] inHigh,
    input wire logic suppress,
    output logic [WORDS-1:0] hit
);
    import mata_pkg::*;

    // ==========================================================
    // One pattern and one registered match per word
    genvar w;
    generate
        for (w = 0; w < WORDS; w++) begin : g_word
            logic [WIDTH-1:0] pattern_reg;
            wire logic [WIDTH-1:0] seen = (w < SPLIT) ? inLow : inHigh;
            // Zero in both true and inverted slot leaves the bit out
            wire logic match = ((pattern_reg & ~seen) == '0);
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    pattern_reg <= '0;
                end else if (wrEn && (wrIdx == IDX_W'(w))) begin
                    pattern_reg <= wrData[WIDTH-1:0];
                end
            end
            // Several words may hit at once
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    hit[w] <= 1'b0;
                end else begin
                    hit[w] <= match && !suppress;
                end
            end
        end
    endgenerate

endmodule // mata_match_plane

// [src/mata_or_plane.sv]
// Programmable OR plane: selected words combine bit by bit.
// Assumes select lines are stable for the phase in which the output is used.
`timescale 1ns/1ps
module mata_or_plane #(
    parameter int WORDS = 89,
    parameter int WIDTH = 7,
    parameter bit INVERT = 1'b0,
    parameter bit REGISTERED = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wrEn,
    input wire logic [mata_pkg::IDX_W-1:0] wrIdx,
    input wire logic [mata_pkg::AXI_DATA_W-1:0] wrData,
    input wire logic [WORDS-1:0] sel,
    output logic [WIDTH-1:0] orOut
);
    import mata_pkg::*;

    logic [WIDTH-1:0] conn [WORDS];
    logic [WIDTH-1:0] column;
    logic [WIDTH-1:0] shaped;

    // ==========================================================
    // Stored words; an inverting plane connects on zero bits
    genvar w, b;
    generate
        for (w = 0; w < WORDS; w++) begin : g_word
            logic [WIDTH-1:0] word_reg;
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    word_reg <= INVERT ? {WIDTH{1'b1}} : '0;
                end else if (wrEn && (wrIdx == IDX_W'(w))) begin
                    word_reg <= wrData[WIDTH-1:0];
                end
            end
            assign conn[w] = (INVERT ? ~word_reg : word_reg) & {WIDTH{sel[w]}};
        end
        for (b = 0; b < WIDTH; b++) begin : g_bit
            logic [WORDS-1:0] lane;
            for (w = 0; w < WORDS; w++) begin : g_lane
                assign lane[w] = conn[w][b];
            end
            assign column[b] = |lane;
        end
    endgenerate

    assign shaped = INVERT ? ~column : column;

    // ==========================================================
    // Optional output register
    generate
        if (REGISTERED) begin : g_reg
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    orOut <= INVERT ? {WIDTH{1'b1}} : '0;
                end else begin
                    orOut <= shaped;
                end
            end
        end else begin : g_comb
            assign orOut = shaped;
        end
    endgenerate

endmodule // mata_or_plane

// [src/mata_pkg.sv]
// Shared constants, field layouts and types of the next-address mapper.
// Assumes a single clk domain; all array words are loaded over AXI4-Lite.
package mata_pkg;

    // ==========================================================
    // Widths and array sizes
    localparam int LC_W = 11;
    localparam int HOLD_W = 16;
    localparam int BYTE_W = 8;
    localparam int CODE_W = 7;
    localparam int INTR_W = 7;
    localparam int TSR_W = 3;
    localparam int FB_W = 2;
    localparam int IDX_W = 8;
    localparam int A1_WORDS = 88;
    localparam int A1_W = 24;
    localparam int A2_WORDS = 89;
    localparam int A3_WORDS = 100;
    localparam int A3_SPLIT = 16;
    localparam int A3_W = 28;
    localparam int A4_WORDS = 100;
    localparam int A4_W = 20;
    localparam int AXI_ADDR_W = 13;
    localparam int AXI_DATA_W = 32;

    // ==========================================================
    // Bit positions
    localparam int BFIELD_LO_BIT = 4;
    localparam int BFIELD_HI_BIT = 5;
    localparam int TSR_SEL_BIT = 2;
    localparam int CTRL_RUN_BIT = 0;
    localparam int STAT_TSR_LSB = 12;
    localparam int STAT_PHASE_LSB = 16;
    localparam int REGION_LSB = 10;
    localparam int IDX_LSB = 2;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [AXI_ADDR_W-1:0] ADDR_CTRL = 13'h0000;
    localparam logic [AXI_ADDR_W-1:0] ADDR_STATUS = 13'h0004;
    localparam logic [AXI_ADDR_W-1:0] ADDR_HOLDER = 13'h0008;
    localparam logic [2:0] REGION_REGS = 3'h0;
    localparam logic [2:0] REGION_A1 = 3'h1;
    localparam logic [2:0] REGION_A2 = 3'h2;
    localparam logic [2:0] REGION_A3 = 3'h3;
    localparam logic [2:0] REGION_A4 = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] STRB_FULL = 4'hF;

    // ==========================================================
    // Reset values and steps
    localparam logic [LC_W-1:0] LC_RESET = 11'h000;
    localparam logic [LC_W-1:0] LC_STEP = 11'h001;
    localparam logic [TSR_W-1:0] TSR_RESET = 3'h0;
    localparam logic [HOLD_W-1:0] HOLD_RESET = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_IDLE = 7'h7F;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        PH_FETCH = 2'b00,
        PH_MATCH = 2'b01,
        PH_CODE = 2'b11,
        PH_RESOLVE = 2'b10
    } mata_phase_t;

    typedef struct packed {
        logic [3:0] userBits;
        logic forceLine;
        logic returnLoad;
        logic [HOLD_W-1:0] word;
    } mata_microword_t;

    typedef struct packed {
        logic [2:0] spare;
        logic loadTranslate;
        logic loadReturn;
        logic loadPhase;
        logic [TSR_W-1:0] phaseNext;
        logic [LC_W-1:0] address;
    } mata_a4_word_t;

endpackage

// [src/microaddress_translation_array.sv]
// Next-address mapper: counter, holder, phase register and four arrays.
// Assumes the data chip and microcode store run on clk; each machine cycle
// is four clk cycles, walked by an internal phase machine.
`timescale 1ns/1ps
module microaddress_translation_array (
    input wire logic clk,
    input wire logic reset,
    input wire logic [mata_pkg::AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [mata_pkg::AXI_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [mata_pkg::AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [mata_pkg::AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire mata_pkg::mata_microword_t microwordBus,
    input wire logic [mata_pkg::HOLD_W-1:0] dataAccessLines,
    input wire logic [mata_pkg::INTR_W-1:0] interruptLatches,
    input wire logic qSignal,
    input wire logic jumpRequest,
    input wire logic [mata_pkg::LC_W-1:0] jumpAddress,
    input wire logic [mata_pkg::LC_W-1:0] returnAddress,
    input wire logic inputWordOp,
    input wire logic loadHolderOp,
    input wire logic [7:0] bField,
    output logic [mata_pkg::LC_W-1:0] counterBusLines,
    output mata_pkg::mata_phase_t machinePhase
);
    import mata_pkg::*;

    // ==========================================================
    // State
    mata_phase_t phase_reg, phase_next;
    logic [LC_W-1:0] counter_reg, counter_next;
    logic [HOLD_W-1:0] holder_reg, holder_next;
    logic [TSR_W-1:0] tsr_reg, tsr_next;
    mata_microword_t micro_reg;
    logic run_reg;
    logic [A1_WORDS-1:0] a1Hit;
    logic [CODE_W-1:0] stateCode;
    logic [A3_WORDS-1:0] a3Hit;
    logic [A4_W-1:0] a4Raw;
    mata_a4_word_t a4Word;

    // ==========================================================
    // Phase machine: one machine cycle is four clk cycles
    wire logic cycleEnd = (phase_reg == PH_RESOLVE) && run_reg;
    always_comb begin
        case (phase_reg)
            PH_FETCH: phase_next = run_reg ? PH_MATCH : PH_FETCH;
            PH_MATCH: phase_next = PH_CODE;
            PH_CODE: phase_next = PH_RESOLVE;
            PH_RESOLVE: phase_next = run_reg ? PH_FETCH : PH_RESOLVE;
            default: phase_next = PH_FETCH;
        endcase
    end

    // ==========================================================
    // Counter source selection, fourth array first
    assign a4Word = mata_a4_word_t'(a4Raw);
    wire logic takeTranslate = a4Word.loadTranslate;
    wire logic takeReturn = a4Word.loadReturn || micro_reg.returnLoad;
    wire logic [LC_W-1:0] counterInc = counter_reg + LC_STEP;
    assign counter_next = !cycleEnd ? counter_reg :
                          takeTranslate ? a4Word.address :
                          takeReturn ? returnAddress :
                          jumpRequest ? jumpAddress : counterInc;

    // Holder load: input word with a byte bit set wins over load-holder op
    wire logic holdFromData = inputWordOp && (bField[BFIELD_LO_BIT] || bField[BFIELD_HI_BIT]);
    assign holder_next = !cycleEnd ? holder_reg :
                         holdFromData ? dataAccessLines :
                         loadHolderOp ? microwordBus.word : holder_reg;
    assign tsr_next = (cycleEnd && a4Word.loadPhase) ? a4Word.phaseNext : tsr_reg;

    // Machine-cycle registers all move on the phase-one edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_reg <= PH_FETCH;
            counter_reg <= LC_RESET;
            holder_reg <= HOLD_RESET;
            tsr_reg <= TSR_RESET;
            micro_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            counter_reg <= counter_next;
            holder_reg <= holder_next;
            tsr_reg <= tsr_next;
            if (cycleEnd) begin
                micro_reg <= microwordBus;
            end
        end
    end

    assign counterBusLines = counter_reg;
    assign machinePhase = phase_reg;

    // ==========================================================
    // Array inputs; force line is held in the latched microword
    wire logic [A1_W-1:0] a1In = {1'b0, counter_reg, 1'b0, ~counter_reg};
    wire logic [BYTE_W-1:0] holdByte = tsr_reg[TSR_SEL_BIT] ? holder_reg[BYTE_W-1:0]
                                                            : holder_reg[HOLD_W-1:BYTE_W];
    wire logic [FB_W-1:0] fb = tsr_reg[FB_W-1:0];
    wire logic [A3_W-1:0] a3Intr = {qSignal, fb, ~fb, stateCode,
                                    1'b0, interruptLatches, 1'b0, ~interruptLatches};
    wire logic [A3_W-1:0] a3Byte = {qSignal, fb, ~fb, stateCode, holdByte, ~holdByte};
    wire logic [A2_WORDS-1:0] a2Sel = {micro_reg.forceLine, a1Hit};

    // ==========================================================
    // Bus write side decode
    logic [AXI_ADDR_W-1:0] wrAddr_reg;
    logic [AXI_DATA_W-1:0] wrData_reg;
    logic [3:0] wrStrb_reg;
    wire logic doWrite = !awready && !wready && !bvalid;
    wire logic [2:0] wrRegion = wrAddr_reg[AXI_ADDR_W-1:REGION_LSB];
    wire logic [IDX_W-1:0] wrIdx = wrAddr_reg[REGION_LSB-1:IDX_LSB];
    wire logic strbOk = (wrStrb_reg == STRB_FULL);
    wire logic wrA1 = (wrRegion == REGION_A1) && (wrIdx < IDX_W'(A1_WORDS));
    wire logic wrA2 = (wrRegion == REGION_A2) && (wrIdx < IDX_W'(A2_WORDS));
    wire logic wrA3 = (wrRegion == REGION_A3) && (wrIdx < IDX_W'(A3_WORDS));
    wire logic wrA4 = (wrRegion == REGION_A4) && (wrIdx < IDX_W'(A4_WORDS));
    wire logic wrCtrl = (wrAddr_reg == ADDR_CTRL);
    wire logic wrRo = (wrAddr_reg == ADDR_STATUS) || (wrAddr_reg == ADDR_HOLDER);
    wire logic wrHit = wrA1 || wrA2 || wrA3 || wrA4 || wrCtrl || wrRo;
    wire logic wrGo = doWrite && strbOk;

    // ==========================================================
    // The four arrays
    mata_match_plane #(.WORDS(A1_WORDS), .WIDTH(A1_W), .SPLIT(0)) u_array1 (
        .clk(clk), .reset(reset), .wrEn(wrGo && wrA1), .wrIdx(wrIdx), .wrData(wrData_reg),
        .inLow(a1In), .inHigh(a1In), .suppress(micro_reg.forceLine), .hit(a1Hit)
    );

    mata_or_plane #(.WORDS(A2_WORDS), .WIDTH(CODE_W), .INVERT(1'b1), .REGISTERED(1'b1)) u_array2 (
        .clk(clk), .reset(reset), .wrEn(wrGo && wrA2), .wrIdx(wrIdx), .wrData(wrData_reg),
        .sel(a2Sel), .orOut(stateCode)
    );

    mata_match_plane #(.WORDS(A3_WORDS), .WIDTH(A3_W), .SPLIT(A3_SPLIT)) u_array3 (
        .clk(clk), .reset(reset), .wrEn(wrGo && wrA3), .wrIdx(wrIdx), .wrData(wrData_reg),
        .inLow(a3Intr), .inHigh(a3Byte), .suppress(1'b0), .hit(a3Hit)
    );

    // Combinational so its word is ready at the phase-one edge
    mata_or_plane #(.WORDS(A4_WORDS), .WIDTH(A4_W), .INVERT(1'b0), .REGISTERED(1'b0)) u_array4 (
        .clk(clk), .reset(reset), .wrEn(wrGo && wrA4), .wrIdx(wrIdx), .wrData(wrData_reg),
        .sel(a3Hit), .orOut(a4Raw)
    );

    // ==========================================================
    // AXI4-Lite write channel: address and data taken in either order
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            wrAddr_reg <= '0;
            wrData_reg <= '0;
            wrStrb_reg <= '0;
            run_reg <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                wrAddr_reg <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wrData_reg <= wdata;
                wrStrb_reg <= wstrb;
                wready <= 1'b0;
            end
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp <= (wrHit && strbOk) ? RESP_OKAY : RESP_SLVERR;
                if (wrGo && wrCtrl) begin
                    run_reg <= wrData_reg[CTRL_RUN_BIT];
                end
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read side: status shows counter, phase register and phase
    wire logic [2:0] rdRegion = araddr[AXI_ADDR_W-1:REGION_LSB];
    wire logic rdArray = (rdRegion == REGION_A1) || (rdRegion == REGION_A2) ||
                         (rdRegion == REGION_A3) || (rdRegion == REGION_A4);
    wire logic [AXI_DATA_W-1:0] statusWord = (AXI_DATA_W'(phase_reg) << STAT_PHASE_LSB) |
                                             (AXI_DATA_W'(tsr_reg) << STAT_TSR_LSB) |
                                             AXI_DATA_W'(counter_reg);
    wire logic [AXI_DATA_W-1:0] rdMux = (araddr == ADDR_CTRL) ? AXI_DATA_W'(run_reg) :
                                        (araddr == ADDR_STATUS) ? statusWord :
                                        (araddr == ADDR_HOLDER) ? AXI_DATA_W'(holder_reg) : '0;
    wire logic rdHit = (araddr == ADDR_CTRL) || (araddr == ADDR_STATUS) ||
                       (araddr == ADDR_HOLDER) || rdArray;

    // Array words are write-only and read back as zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rdMux;
                rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    sequence s_walk_phases;
        (phase_reg == PH_MATCH) ##1 (phase_reg == PH_CODE) ##1 (phase_reg == PH_RESOLVE);
    endsequence

    sequence s_plain_step;
        cycleEnd && !takeTranslate && !takeReturn && !jumpRequest;
    endsequence

    AST_PHASE_WALK: assert property (@(posedge clk) disable iff (reset)
        (phase_reg == PH_FETCH) && run_reg |=> s_walk_phases)
        else $error("phase walk broken");

    AST_HOLDER_FROM_DATA: assert property (@(posedge clk) disable iff (reset)
        cycleEnd && holdFromData |=> (holder_reg == $past(dataAccessLines)))
        else $error("holder missed data lines");

    AST_COUNTER_STEP: assert property (@(posedge clk) disable iff (reset)
        s_plain_step |=> (counter_reg == $past(counter_reg) + LC_STEP))
        else $error("counter did not step");

    AST_COUNTER_JUMP: assert property (@(posedge clk) disable iff (reset)
        cycleEnd && !takeTranslate && !takeReturn && jumpRequest |=> (counter_reg == $past(jumpAddress)))
        else $error("counter missed jump address");

    AST_COUNTER_HOLD: assert property (@(posedge clk) disable iff (reset)
        !cycleEnd |=> $stable(counter_reg) && $stable(holder_reg))
        else $error("counter moved outside phase one");

    AST_FORCE_BLOCKS: assert property (@(posedge clk) disable iff (reset)
        micro_reg.forceLine && (phase_reg == PH_CODE) |-> (a1Hit == '0))
        else $error("first array not blocked by force line");

    AST_CODE_IDLE: assert property (@(posedge clk) disable iff (reset)
        (phase_reg == PH_CODE) && $stable(a2Sel) && (a2Sel == '0) |-> (stateCode == CODE_IDLE))
        else $error("idle code not all ones");

    AST_NO_MATCH_NO_LOAD: assert property (@(posedge clk) disable iff (reset)
        (a3Hit == '0) |-> (a4Raw == '0))
        else $error("fourth array active without a match");

    AST_TSR_GATED: assert property (@(posedge clk) disable iff (reset)
        !(cycleEnd && a4Word.loadPhase) |=> $stable(tsr_reg))
        else $error("phase register loaded without control");

    AST_BUS_HOLD: assert property (@(posedge clk) disable iff (reset)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");

    // Loads taken from the fourth array and the return path
    sequence s_translate_edge;
        cycleEnd && takeTranslate;
    endsequence

    sequence s_return_edge;
        cycleEnd && !takeTranslate && takeReturn;
    endsequence

    AST_TRANSLATE_LOAD: assert property (@(posedge clk) disable iff (reset)
        s_translate_edge |=> (counter_reg == $past(a4Word.address)))
        else $error("counter missed array word");

    AST_RETURN_LOAD: assert property (@(posedge clk) disable iff (reset)
        s_return_edge |=> (counter_reg == $past(returnAddress)))
        else $error("counter missed return value");

    AST_TSR_LOAD: assert property (@(posedge clk) disable iff (reset)
        cycleEnd && a4Word.loadPhase |=> (tsr_reg == $past(a4Word.phaseNext)))
        else $error("phase register missed load");

    AST_HOLDER_KEEP: assert property (@(posedge clk) disable iff (reset)
        cycleEnd && !holdFromData && !loadHolderOp |=> $stable(holder_reg))
        else $error("holder loaded without op");

    AST_PHASE_PARK: assert property (@(posedge clk) disable iff (reset)
        !run_reg && (phase_reg == PH_FETCH) |=> (phase_reg == PH_FETCH))
        else $error("phase moved while stopped");

    AST_WRITE_ANSWER: assert property (@(posedge clk) disable iff (reset)
        awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");

    AST_READ_ANSWER: assert property (@(posedge clk) disable iff (reset)
        arvalid && arready |=> rvalid)
        else $error("read answer late");

    AST_READ_HOLD: assert property (@(posedge clk) disable iff (reset)
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");

endmodule // microaddress_translation_array
